//--- logic/uatx_baud.sv
`timescale 1ns/1ps
`default_nettype none

module uatx_baud
	import uatx_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        RESET_I,
	input  wire logic        restart_i,
	input  wire logic [15:0] divisor_i,
	output logic             tick_o
);

	logic [15:0] cnt_q;
	wire  [15:0] period;

	// A zero divisor would tick only once in 65536 clocks; treat it as one
	assign period = (divisor_i == '0) ? DIVISOR_ONE : divisor_i;
	assign tick_o = !restart_i && (cnt_q >= period - DIVISOR_ONE);

	always_ff @(posedge CLK_I) begin
		if (RESET_I || restart_i || tick_o) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + DIVISOR_ONE;
		end
	end

endmodule

`default_nettype wire

//--- logic/uatx_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module uatx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input  wire logic             CLK_I,
	input  wire logic             RESET_I,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	wire              push;
	wire              pop;

	assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem_q[rd_q];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge CLK_I) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= AW'((wr_q + 1'b1) % DEPTH);
			end
			if (pop) begin
				rd_q <= AW'((rd_q + 1'b1) % DEPTH);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

`default_nettype wire

//--- logic/uatx_pkg.sv
package uatx_pkg;

	// ----------------------------------------------------------------
	// Register map (word index = address)
	// ----------------------------------------------------------------
	localparam logic [2:0] ADDR_TX_DATA   = 3'h0;
	localparam logic [2:0] ADDR_CONTROL   = 3'h1;
	localparam logic [2:0] ADDR_STATUS    = 3'h2;
	localparam logic [2:0] ADDR_DIVISOR   = 3'h3;

	// Control register fields
	localparam int CTL_TX_EN   = 0;
	localparam int CTL_PAR_EN  = 1;
	localparam int CTL_PAR_ODD = 2;
	localparam int CTL_STOP2   = 3;
	localparam int CTL_FLOW    = 4;
	localparam int CTL_MDROP   = 5;
	localparam int CTL_MARKER  = 6;
	localparam int CTL_IRQ_EN  = 7;

	// Status register fields
	localparam int STA_HOLD_EMPTY = 0;
	localparam int STA_LINE_IDLE  = 1;
	localparam int STA_CTS_LEVEL  = 2;

	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [15:0] DIVISOR_RESET = 16'h0001;
	localparam logic [15:0] DIVISOR_ONE   = 16'h0001;

	// Character framing
	localparam int          DATA_BITS  = 8;
	localparam logic [3:0]  LAST_DATA  = 4'h7;
	localparam int          FIFO_DEPTH = 4;

	typedef struct packed {
		logic       marker;
		logic [7:0] data;
	} uatx_word_s;

	localparam int WORD_W = $bits(uatx_word_s);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_DATA,
		ST_EXTRA,
		ST_STOP1,
		ST_STOP2
	} uatx_state_e;

endpackage

//--- logic/uatx_top.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - With parity on and multidrop off, append even or odd parity bit after data.
// - Each character: one low start bit, then one or two high stops.
// - Flow gate enable set: clear-to-send input gates start; else ignored.
// - Holding-empty flag is 1 when a byte can be accepted, else 0.
// - Written byte moves to shifter and is sent with no software help.
// - Marker is captured with each byte; later changes affect next only.
// - Interrupt request raised while holding space is free, if enabled.
// - Multidrop mode select sends nine-bit characters with marker bit.
// - No character starts while transmit enable bit is clear.
module uatx_top
	import uatx_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        RESET_I,
	input  wire logic [2:0]  ADDR_I,
	input  wire logic [15:0] WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [15:0] RDATA_O,
	input  wire logic        CTS_N_I,
	output logic             TXD_O,
	output logic             IRQ_O
);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [7:0]  control_q;
	logic [15:0] divisor_q;
	logic [15:0] rdata_q;

	wire wr_data    = WR_I && (ADDR_I == ADDR_TX_DATA);
	wire wr_control = WR_I && (ADDR_I == ADDR_CONTROL);
	wire wr_divisor = WR_I && (ADDR_I == ADDR_DIVISOR);

	wire tx_enable  = control_q[CTL_TX_EN];
	wire par_enable = control_q[CTL_PAR_EN];
	wire par_odd    = control_q[CTL_PAR_ODD];
	wire two_stops  = control_q[CTL_STOP2];
	wire flow_gate  = control_q[CTL_FLOW];
	wire mdrop_mode = control_q[CTL_MDROP];
	wire marker_bit = control_q[CTL_MARKER];
	wire irq_enable = control_q[CTL_IRQ_EN];

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			control_q <= CONTROL_RESET;
			divisor_q <= DIVISOR_RESET;
		end else begin
			if (wr_control) begin
				control_q <= WDATA_I[7:0];
			end
			if (wr_divisor) begin
				divisor_q <= WDATA_I;
			end
		end
	end

	// ----------------------------------------------------------------
	// Holding buffer
	// ----------------------------------------------------------------
	uatx_word_s in_word;
	uatx_word_s out_word;
	logic [WORD_W-1:0] out_bits;
	logic        fifo_ready;
	logic        fifo_valid;
	logic        load;

	// Marker is sampled with the byte, so a later change cannot reach it
	assign in_word.marker = marker_bit;
	assign in_word.data   = WDATA_I[7:0];
	assign out_word       = uatx_word_s'(out_bits);

	// Writes to a full buffer are dropped; software must poll first
	uatx_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.CLK_I       (CLK_I),
		.RESET_I     (RESET_I),
		.in_valid_i  (wr_data),
		.in_ready_o  (fifo_ready),
		.in_data_i   (in_word),
		.out_valid_o (fifo_valid),
		.out_ready_i (load),
		.out_data_o  (out_bits)
	);

	wire hold_empty = fifo_ready;

	// ----------------------------------------------------------------
	// Shifter
	// ----------------------------------------------------------------
	uatx_state_e state_q;
	uatx_state_e state_d;
	logic [7:0]  shift_q;
	logic [3:0]  bit_q;
	logic        extra_q;
	logic        txd_q;
	logic        tick;

	function automatic logic parity_of(input logic [7:0] d, input logic odd);
		parity_of = (^d) ^ odd;
	endfunction

	// Low clear-to-send means the far end is ready
	wire cts_ok = !flow_gate || !CTS_N_I;
	wire go     = (state_q == ST_IDLE) && fifo_valid && tx_enable && cts_ok;
	assign load = go;
	wire has_extra  = mdrop_mode || par_enable;

	uatx_baud u_baud (
		.CLK_I     (CLK_I),
		.RESET_I   (RESET_I),
		.restart_i (go),
		.divisor_i (divisor_q),
		.tick_o    (tick)
	);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (go) begin
					state_d = ST_START;
				end
			end
			ST_START: begin
				if (tick) begin
					state_d = ST_DATA;
				end
			end
			ST_DATA: begin
				if (tick && bit_q == LAST_DATA) begin
					state_d = has_extra ? ST_EXTRA : ST_STOP1;
				end
			end
			ST_EXTRA: begin
				if (tick) begin
					state_d = ST_STOP1;
				end
			end
			ST_STOP1: begin
				if (tick) begin
					state_d = two_stops ? ST_STOP2 : ST_IDLE;
				end
			end
			ST_STOP2: begin
				if (tick) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			state_q <= ST_IDLE;
			shift_q <= '0;
			bit_q   <= '0;
			extra_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (go) begin
				shift_q <= out_word.data;
				bit_q   <= '0;
				// Marker takes the extra slot; parity only without multidrop
				extra_q <= mdrop_mode ? out_word.marker
					: parity_of(out_word.data, par_odd);
			end else if (tick && state_q == ST_DATA) begin
				shift_q <= {1'b0, shift_q[7:1]};
				bit_q   <= bit_q + 4'h1;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			txd_q <= 1'b1;
		end else begin
			case (state_d)
				ST_START: txd_q <= 1'b0;
				// Next bit shows only on the tick that shifts it in
				ST_DATA:  txd_q <= (state_q == ST_DATA && tick) ? shift_q[1]
					: shift_q[0];
				ST_EXTRA: txd_q <= extra_q;
				default:  txd_q <= 1'b1;
			endcase
		end
	end

	assign TXD_O = txd_q;
	assign IRQ_O = irq_enable && hold_empty;

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	wire [15:0] status_word = {13'h0000, !CTS_N_I,
		(state_q == ST_IDLE), hold_empty};
	wire [15:0] rd_mux = (ADDR_I == ADDR_CONTROL) ? {8'h00, control_q}
		: (ADDR_I == ADDR_STATUS) ? status_word
		: (ADDR_I == ADDR_DIVISOR) ? divisor_q : 16'h0000;

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			rdata_q <= 16'h0000;
		end else if (RD_I) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	assign RDATA_O = rdata_q;

endmodule

`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
	import uatx_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        cts_n = 1'b1;
	logic        txd;
	logic        irq;
	logic [2:0]  addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic [3:0]  len = 4'hA;
	logic [7:0]  cfg [6] = '{8'h01, 8'h03, 8'h07, 8'h09, 8'h21, 8'h61};
	logic [7:0]  dat [6] = '{8'h5A, 8'h97, 8'h96, 8'h0F, 8'hC3, 8'h3C};
	int          miscompares = 0;
	int          compares = 0;
	always #20 clk = ~clk;
	uatx_top i_uatx_top (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.CTS_N_I(cts_n), .TXD_O(txd), .IRQ_O(irq));
	uatx_rx_model i_uatx_rx_model (.clk_i(clk), .txd_i(txd),
		.div_i(16'h0002), .len_i(len));
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [2:0] a, input logic [15:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
		@(posedge clk);
	endtask
	task automatic take(input logic [7:0] c, input logic [7:0] d);
		logic [11:0] f;
		logic        x;
		x = c[CTL_MDROP] ? c[CTL_MARKER] : ^d ^ c[CTL_PAR_ODD];
		f = (c[CTL_MDROP] | c[CTL_PAR_EN]) ? {2'h3, x, d, 1'h0} : {3'h7, d, 1'h0};
		for (int i = 0; i < 400 && i_uatx_rx_model.got.size() == 0; i++)
			@(posedge clk);
		chk({4'h0, i_uatx_rx_model.got.pop_front()}, {4'h0, f & ~(12'hFFF << len)});
	endtask
	task automatic close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_reg(ADDR_STATUS, 16'h0003);
		rd_reg(ADDR_CONTROL, 16'h0000);
		rd_reg(3'h7, 16'h0000);
		wr_reg(ADDR_DIVISOR, 16'h0002);
		rd_reg(ADDR_DIVISOR, 16'h0002);
		wr_reg(ADDR_TX_DATA, 16'h005A);
		repeat (60) @(posedge clk);
		chk(16'(i_uatx_rx_model.got.size()), 16'h0000);
		$display("reset test done");
		// Clear-to-send stays inactive here: it must be ignored
		for (int i = 0; i < 6; i++) begin
			len <= 4'hA + (cfg[i][1] | cfg[i][5]) + cfg[i][3];
			wr_reg(ADDR_CONTROL, {8'h00, cfg[i]});
			if (i != 0)
				wr_reg(ADDR_TX_DATA, {8'h00, dat[i]});
			take(cfg[i], dat[i]);
		end
		$display("framing test done");
		len <= 4'hB;
		wr_reg(ADDR_CONTROL, 16'h0061);
		wr_reg(ADDR_TX_DATA, 16'h00A5);
		wr_reg(ADDR_CONTROL, 16'h0021);
		wr_reg(ADDR_TX_DATA, 16'h003C);
		take(8'h61, 8'hA5);
		take(8'h21, 8'h3C);
		$display("marker test done");
		len <= 4'hA;
		wr_reg(ADDR_CONTROL, 16'h0091);
		@(negedge clk);
		chk({15'h0, irq}, 16'h0001);
		@(posedge clk);
		for (int i = 0; i < 5; i++)
			wr_reg(ADDR_TX_DATA, 16'h0011 + 16'(i));
		rd_reg(ADDR_STATUS, 16'h0002);
		@(negedge clk);
		chk({15'h0, irq}, 16'h0000);
		@(posedge clk);
		cts_n <= 1'b0;
		for (int i = 0; i < 4; i++)
			take(8'h91, 8'h11 + 8'(i));
		repeat (60) @(posedge clk);
		chk(16'(i_uatx_rx_model.got.size()), 16'h0000);
		rd_reg(ADDR_STATUS, 16'h0007);
		@(negedge clk);
		chk({15'h0, irq}, 16'h0001);
		@(posedge clk);
		$display("flow test done");
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		close_out();
	end
endmodule
`default_nettype wire

//--- sim/uatx_properties.sv
`timescale 1ns/1ps
`default_nettype none
module uatx_properties
	import uatx_pkg::*;
(
	input wire logic        CLK_I,
	input wire logic        RESET_I,
	input wire logic [2:0]  ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic        WR_I,
	input wire logic        RD_I,
	input wire logic [15:0] RDATA_O,
	input wire logic        CTS_N_I,
	input wire logic        TXD_O,
	input wire logic        IRQ_O
);
	// ----
	// Shadow
	// ----
	logic [7:0]  ctl_q;
	logic [15:0] div_q;
	logic [19:0] hi_q;
	// Idle once high longer than any run inside a frame; divisor 0 unused
	wire         quiet = hi_q > 20'hC * div_q;
	wire         rd_st = RD_I && ADDR_I == ADDR_STATUS;
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			ctl_q <= CONTROL_RESET;
			div_q <= DIVISOR_RESET;
			hi_q  <= 20'h0;
		end else begin
			if (WR_I && ADDR_I == ADDR_CONTROL)
				ctl_q <= WDATA_I[7:0];
			if (WR_I && ADDR_I == ADDR_DIVISOR)
				div_q <= WDATA_I;
			hi_q <= TXD_O ? hi_q + 20'h1 : 20'h0;
		end
	end
	// ----
	// Checks
	// ----
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	a_read_quiet: assert property (!RD_I |=> RDATA_O == 16'h0000)
		else $error("read data not idle");
	a_ctl_readback: assert property (RD_I && ADDR_I == ADDR_CONTROL
		|=> RDATA_O[7:0] == ctl_q) else $error("control readback");
	a_div_readback: assert property (RD_I && ADDR_I == ADDR_DIVISOR
		|=> RDATA_O == div_q) else $error("divisor readback");
	a_irq_masked: assert property (!ctl_q[CTL_IRQ_EN] |-> !IRQ_O)
		else $error("irq while masked");
	a_irq_status: assert property (rd_st && ctl_q[CTL_IRQ_EN]
		|=> RDATA_O[STA_HOLD_EMPTY] == $past(IRQ_O)) else $error("irq vs empty");
	a_cts_status: assert property (rd_st
		|=> RDATA_O[STA_CTS_LEVEL] == !$past(CTS_N_I)) else $error("cts status");
	a_reset_idle: assert property ($fell(RESET_I) |-> TXD_O && !IRQ_O)
		else $error("not idle after reset");
	a_gate_hold: assert property (CTS_N_I [*3] ##0 (ctl_q[CTL_FLOW] && quiet)
		|=> TXD_O) else $error("start while gated");
	a_off_hold: assert property (!ctl_q[CTL_TX_EN] && quiet |=> TXD_O)
		else $error("start while disabled");
	c_start: cover property ($fell(TXD_O) && quiet);
	c_full: cover property (rd_st ##1 !RDATA_O[STA_HOLD_EMPTY]);
	c_irq: cover property ($rose(IRQ_O));
endmodule
bind uatx_top uatx_properties i_uatx_properties (.CLK_I, .RESET_I, .ADDR_I,
	.WDATA_I, .WR_I, .RD_I, .RDATA_O, .CTS_N_I, .TXD_O, .IRQ_O);
`default_nettype wire

//--- sim/uatx_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module uatx_rx_model (
	input wire logic        clk_i,
	input wire logic        txd_i,
	input wire logic [15:0] div_i,
	input wire logic [3:0]  len_i
);
	// Frames with the start bit in bit 0, popped by the bench
	logic [11:0] got[$];
	logic [11:0] frm;
	initial begin
		forever begin
			@(negedge txd_i);
			frm = 12'h000;
			repeat (div_i >> 1) @(posedge clk_i);
			// No wait after the last bit, so a prompt next start is not missed
			for (int i = 0; i < len_i; i++) begin
				if (i > 0)
					repeat (div_i) @(posedge clk_i);
				frm[i] = txd_i;
			end
			got.push_back(frm);
		end
	end
endmodule
`default_nettype wire
